// ---- pkg/cpu_pkg.sv ----
package cpu_pkg;
    // Bus geometry
    localparam int ADDR_W = 15;
    localparam int PC_W = 12;
    localparam logic [14:0] REG_CTRL = 15'h0000;
    localparam logic [14:0] REG_STATUS = 15'h0004;
    localparam logic [14:0] REG_TIMER_CTRL = 15'h0008;
    localparam logic [14:0] REG_TIMER_COUNT = 15'h000C;
    localparam int DATA_WIN_LSB = 10;
    localparam logic [4:0] DATA_WIN_TAG = 5'h01;
    localparam int PROG_WIN_LSB = 14;
    localparam logic [0:0] PROG_WIN_TAG = 1'h1;
    // Control and status fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_Z_BIT = 0;
    localparam int ST_C_BIT = 1;
    localparam int ST_STOP_BIT = 2;
    localparam int ST_WAIT_BIT = 3;
    localparam int ST_ISR_BIT = 4;
    localparam int ST_PC_LSB = 16;
    // Timer status/control fields and reset values
    localparam int TMZ_BIT = 7;
    localparam int ETI_BIT = 5;
    localparam int PSI_BIT = 3;
    localparam logic [7:0] TIMER_STATUS_CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'hFF;
    // Data space locations
    localparam logic [7:0] X_ADDR = 8'h80;
    localparam logic [7:0] Y_ADDR = 8'h81;
    localparam logic [7:0] SHORT_BASE = 8'h80;
    localparam logic [7:0] ACC_ADDR = 8'hFF;
    localparam logic [7:0] TCOUNT_ADDR = 8'h08;
    localparam logic [7:0] TIMER_STATUS_CONTROL_ADDR = 8'h09;
    // Opcodes of the B0-B7 row; all but MVI are inherent
    localparam logic [7:0] OP_MVI = 8'hB0;
    localparam logic [7:0] OP_RSV_B1 = 8'hB1;
    localparam logic [7:0] OP_RTI = 8'hB2;
    localparam logic [7:0] OP_RTS = 8'hB3;
    localparam logic [7:0] OP_COMA = 8'hB4;
    localparam logic [7:0] OP_ROTATE_LEFT_ACCUMULATOR_OP = 8'hB5;
    localparam logic [7:0] OP_STOP = 8'hB6;
    localparam logic [7:0] OP_WAIT = 8'hB7;
    // Memory-group sub operations (low three opcode bits)
    localparam logic [2:0] SUB_LDA = 3'h0;
    localparam logic [2:0] SUB_STA = 3'h1;
    localparam logic [2:0] SUB_ADD = 3'h2;
    localparam logic [2:0] SUB_SUB = 3'h3;
    localparam logic [2:0] SUB_CMP = 3'h4;
    localparam logic [2:0] SUB_AND = 3'h5;
    localparam logic [2:0] SUB_INC = 3'h6;
    localparam logic [2:0] SUB_DEC = 3'h7;
    // Instruction cycle counts
    localparam logic [2:0] CYC_SHORT = 3'h2;
    localparam logic [2:0] CYC_STD = 3'h4;
    localparam logic [2:0] CYC_BTB = 3'h5;
    // Oscillator stabilisation delay, least time
    localparam int CLK_PERIOD_NS = 8;
    localparam int STAB_TIME_NS = 1920;
    localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STAB_COUNT_DEF = 8'(STAB_CYCLES);
    // Interrupt vector, plain default
    localparam logic [11:0] IRQ_VECTOR_DEF = 12'hFF8;

    typedef enum logic [2:0] {
        ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_COM, ALU_ROL, ALU_INC, ALU_DEC
    } alu_op_type;
endpackage : cpu_pkg

// ---- design/cpu_alu.sv ----
`timescale 1ns/100ps
module cpu_alu
    import cpu_pkg::*;
(
    // Operation and operands
    input wire alu_op_type op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    // Result and carry/borrow
    output logic [7:0] res,
    output logic cout
);
    logic [8:0] sum9;
    logic [8:0] dif9;

    // Nine-bit sum and difference give carry and borrow directly
    assign sum9 = {1'b0, a} + {1'b0, b};
    assign dif9 = {1'b0, a} - {1'b0, b};

    // Result select; ops without a carry effect pass carry through
    always_comb begin
        res = b;
        cout = cin;
        case (op)
            ALU_ADD: begin
                res = sum9[7:0];
                cout = sum9[8];
            end
            ALU_SUB: begin
                res = dif9[7:0];
                cout = dif9[8];
            end
            ALU_AND: res = a & b;
            ALU_COM: begin
                res = ~a;
                cout = 1'b1;
            end
            ALU_ROL: begin
                res = {a[6:0], cin};
                cout = a[7];
            end
            ALU_INC: res = b + 8'h01;
            ALU_DEC: res = b - 8'h01;
            default: res = b;
        endcase
    end
endmodule : cpu_alu

// ---- design/cpu_timer.sv ----
`timescale 1ns/100ps
module cpu_timer
    import cpu_pkg::*;
#(
    parameter logic [7:0] STAB_COUNT = STAB_COUNT_DEF
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Counting control
    input wire logic count_en,
    input wire logic stab_load,
    // Register writes
    input wire logic wr_ctrl,
    input wire logic wr_count,
    input wire logic [7:0] wr_data,
    // State
    output logic [7:0] ctrl_q,
    output logic [7:0] count_q,
    output logic stab_q
);
    logic zero_hit;

    // Decrement that lands on zero; the stabilisation run never flags
    assign zero_hit = count_en & ~stab_q & ~wr_count & (count_q == 8'h01);

    // Counter: stabilisation run ends at all zeros
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= COUNT_RESET;
            stab_q <= 1'b0;
        end else if (ce) begin
            if (stab_load) begin
                count_q <= STAB_COUNT;
                stab_q <= 1'b1;
            end else if (stab_q) begin
                if (count_q == 8'h00) stab_q <= 1'b0;
                else count_q <= count_q - 8'h01;
            end else if (wr_count) begin
                count_q <= wr_data;
            end else if (count_en) begin
                count_q <= count_q - 8'h01;
            end
        end
    end

    // Control register; a zero event wins over a clearing write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= TIMER_STATUS_CONTROL_RESET;
        end else if (ce) begin
            if (wr_ctrl) ctrl_q <= wr_data;
            if (zero_hit) ctrl_q[TMZ_BIT] <= 1'b1;
        end
    end
endmodule : cpu_timer

// ---- design/cpu_core.sv ----
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module cpu_core
    import cpu_pkg::*;
#(
    parameter int PROG_DEPTH = 4096,
    parameter int STACK_DEPTH = 4,
    parameter logic [11:0] IRQ_VECTOR = IRQ_VECTOR_DEF,
    parameter logic [7:0] STAB_COUNT = STAB_COUNT_DEF
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // External interrupt request
    input wire logic irq_n,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

    typedef enum logic [2:0] {S_HALT, S_EXEC, S_STOP, S_WAIT, S_STAB} state_type;

    logic [7:0] prog_mem [PROG_DEPTH];
    logic [7:0] data_mem [256];
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];

    state_type state_q;
    logic [PC_W-1:0] pc_q;
    logic [2:0] cyc_q;
    logic z_q;
    logic c_q;
    logic in_isr_q;
    logic wake_q;
    logic run_q;
    logic [SP_W-1:0] sp_q;
    logic wait_q;
    logic [31:0] rdata_q;

    logic [7:0] tmr_ctrl;
    logic [7:0] tmr_count;
    logic tmr_stab;

    // Data space read with timer overlay; all sources are arguments so every caller tracks them
    function automatic logic [7:0] data_rd(input logic [7:0] a, m, tc, tn);
        logic [7:0] v;
        v = m;
        if (a == TIMER_STATUS_CONTROL_ADDR) v = tc;
        if (a == TCOUNT_ADDR) v = tn;
        return v;
    endfunction : data_rd

    // Instruction bytes at the program counter
    logic [PC_W-1:0] pc1;
    logic [PC_W-1:0] pc2;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    assign pc1 = pc_q + 12'h001;
    assign pc2 = pc_q + 12'h002;
    assign op = prog_mem[pc_q];
    assign b1 = prog_mem[pc1];
    assign b2 = prog_mem[pc2];

    // Opcode classes
    logic is_branch;
    logic is_ext;
    logic is_short;
    logic is_btb;
    logic is_bsc;
    logic is_mem;
    logic is_mvi;
    logic is_coma;
    logic is_rotate_left_accumulator_op;
    logic is_rti;
    logic is_rts;
    logic is_stop;
    logic is_wait;
    assign is_branch = ~op[7];
    assign is_ext = (op[7:5] == 3'h4);
    assign is_short = (op[7:5] == 3'h5) & op[3];
    assign is_btb = (op[7:4] == 4'hC);
    assign is_bsc = (op[7:4] == 4'hD);
    assign is_mem = (op[7:5] == 3'h7);
    assign is_mvi = (op == OP_MVI);
    assign is_coma = (op == OP_COMA);
    assign is_rotate_left_accumulator_op = (op == OP_ROTATE_LEFT_ACCUMULATOR_OP);
    assign is_rti = (op == OP_RTI);
    assign is_rts = (op == OP_RTS);
    assign is_stop = (op == OP_STOP);
    assign is_wait = (op == OP_WAIT);

    // Addressing of the memory group: indirect, immediate, direct, short
    logic mem_imm;
    logic mem_dir;
    logic [2:0] sub;
    logic mem_ok;
    logic alu_grp;
    logic [7:0] ptr;
    logic [7:0] ea;
    logic [7:0] operand;
    logic [7:0] acc;
    assign mem_imm = op[3] & ~op[4];
    assign mem_dir = op[3] & op[4];
    assign sub = is_short ? (op[4] ? (op[2] ? SUB_STA : SUB_DEC) : (op[2] ? SUB_LDA : SUB_INC)) : op[2:0];
    assign mem_ok = ~(is_mem & mem_imm & ((sub == SUB_STA) | (sub == SUB_INC) | (sub == SUB_DEC)));
    assign alu_grp = (is_mem & mem_ok) | is_short;
    assign ptr = op[4] ? data_mem[Y_ADDR] : data_mem[X_ADDR];
    assign ea = is_short ? (SHORT_BASE | {6'h00, op[1:0]}) : (mem_dir ? b1 : ptr);
    assign operand = (is_mem & mem_imm) ? b1 : data_rd(ea, data_mem[ea], tmr_ctrl, tmr_count);
    assign acc = data_mem[ACC_ADDR];

    // Arithmetic unit operand and operation select
    alu_op_type alu_op;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic alu_cout;
    assign alu_op = is_coma ? ALU_COM : is_rotate_left_accumulator_op ? ALU_ROL :
                    (sub == SUB_ADD) ? ALU_ADD :
                    ((sub == SUB_SUB) | (sub == SUB_CMP)) ? ALU_SUB :
                    (sub == SUB_AND) ? ALU_AND :
                    (sub == SUB_INC) ? ALU_INC :
                    (sub == SUB_DEC) ? ALU_DEC : ALU_PASS;
    assign alu_b = (sub == SUB_STA) ? acc : operand;

    cpu_alu u_alu (
        .op(alu_op),
        .a(acc),
        .b(alu_b),
        .cin(c_q),
        .res(alu_res),
        .cout(alu_cout)
    );

    // Bit operations on any data location
    logic [7:0] bit_byte;
    logic [7:0] bit_mask;
    logic tested;
    logic btb_taken;
    logic [7:0] bsc_val;
    assign bit_byte = data_rd(b1, data_mem[b1], tmr_ctrl, tmr_count);
    assign bit_mask = 8'h01 << op[2:0];
    assign tested = bit_byte[op[2:0]];
    assign btb_taken = (tested == op[3]);
    assign bsc_val = op[3] ? (bit_byte | bit_mask) : (bit_byte & ~bit_mask);

    // Single data write port: results always land in one location
    logic core_we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic to_mem;
    assign to_mem = (sub == SUB_STA) | (sub == SUB_INC) | (sub == SUB_DEC);
    assign core_we = is_mvi | is_bsc | is_coma | is_rotate_left_accumulator_op | (alu_grp & (sub != SUB_CMP));
    assign waddr = (is_mvi | is_bsc) ? b1 : (alu_grp & to_mem) ? ea : ACC_ADDR;
    assign wdata = is_mvi ? b2 : is_bsc ? bsc_val : alu_res;

    // Flag effects by instruction class
    logic upd_z;
    logic upd_c;
    logic c_new;
    logic both_flags;
    assign both_flags = (sub == SUB_ADD) | (sub == SUB_SUB) | (sub == SUB_CMP);
    assign upd_z = alu_grp | is_coma | is_rotate_left_accumulator_op;
    assign upd_c = (alu_grp & both_flags) | is_coma | is_rotate_left_accumulator_op | is_btb;
    assign c_new = is_btb ? tested : alu_cout;

    // Length, cycle count, next program counter
    logic [1:0] len;
    logic [2:0] cyc_need;
    logic cond;
    logic br_taken;
    logic [PC_W-1:0] pc_seq;
    logic [PC_W-1:0] pc_next;
    logic [PC_W-1:0] stack_top;
    logic illegal;
    assign illegal = ((op[7:4] == 4'hA) & ~op[3]) | (op == OP_RSV_B1) | ~mem_ok;
    assign len = (is_btb | is_mvi) ? 2'h3 : (is_ext | is_bsc | (is_mem & op[3])) ? 2'h2 : 2'h1;
    assign cyc_need = is_btb ? CYC_BTB :
                      (is_branch | is_rti | is_rts | is_stop | is_wait | illegal) ? CYC_SHORT : CYC_STD;
    assign cond = op[6] ? c_q : z_q;
    assign br_taken = op[5] ? cond : ~cond;
    assign pc_seq = pc_q + {10'h000, len};
    assign stack_top = stack_mem[sp_q - SP_ONE];
    assign pc_next = (is_branch & br_taken) ? (pc1 + {{7{op[4]}}, op[4:0]}) :
                     is_ext ? {op[3:0], b1} :
                     (is_btb & btb_taken) ? (pc_seq + {{4{b2[7]}}, b2}) :
                     (is_rti | is_rts) ? stack_top : pc_seq;

    // Interrupt request: pin level or enabled timer zero, any timer mode
    logic tmr_irq;
    logic irq_req;
    logic in_exec;
    logic int_take;
    logic last;
    logic commit;
    assign tmr_irq = tmr_ctrl[ETI_BIT] & tmr_ctrl[TMZ_BIT];
    assign irq_req = ~irq_n | tmr_irq;
    assign in_exec = (state_q == S_EXEC);
    assign int_take = in_exec & run_q & (cyc_q == 3'h0) & ~in_isr_q & (irq_req | wake_q);
    assign last = (cyc_q == (cyc_need - 3'h1));
    assign commit = in_exec & run_q & ~int_take & last;

    // Sequencer; halting only between instructions keeps them whole
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_HALT;
            pc_q <= '0;
            cyc_q <= 3'h0;
            z_q <= 1'b0;
            c_q <= 1'b0;
            in_isr_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                S_HALT: begin
                    if (run_q) state_q <= S_EXEC;
                end
                S_EXEC: begin
                    if (!run_q && cyc_q == 3'h0) begin
                        state_q <= S_HALT;
                    end else if (int_take) begin
                        pc_q <= IRQ_VECTOR;
                        in_isr_q <= 1'b1;
                        wake_q <= 1'b0;
                    end else if (commit) begin
                        pc_q <= pc_next;
                        cyc_q <= 3'h0;
                        if (upd_z) z_q <= (core_we ? wdata : alu_res) == 8'h00;
                        if (upd_c) c_q <= c_new;
                        if (is_rti) in_isr_q <= 1'b0;
                        if (is_stop) state_q <= S_STOP;
                        if (is_wait) state_q <= S_WAIT;
                    end else begin
                        cyc_q <= cyc_q + 3'h1;
                    end
                end
                S_STOP: begin
                    if (!irq_n) begin
                        state_q <= S_STAB;
                        wake_q <= ~in_isr_q;
                    end
                end
                S_WAIT: begin
                    if (irq_req) begin
                        state_q <= S_EXEC;
                        wake_q <= ~in_isr_q;
                    end
                end
                S_STAB: begin
                    if (!tmr_stab) state_q <= S_EXEC;
                end
                default: state_q <= S_HALT;
            endcase
        end
    end

    // Return stack; overflow wraps silently, so nesting is limited
    logic push;
    logic pop;
    assign push = int_take | (commit & is_ext & ~op[4]);
    assign pop = commit & (is_rti | is_rts);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) sp_q <= '0;
        else if (ce && push) sp_q <= sp_q + SP_ONE;
        else if (ce && pop) sp_q <= sp_q - SP_ONE;
    end

    // Return address: current PC for interrupts, next for calls
    always_ff @(posedge clk) begin
        if (ce && push) stack_mem[sp_q] <= int_take ? pc_q : pc_seq;
    end

    // Bus decode
    logic req;
    logic bus_we;
    logic hit_ctrl;
    logic hit_status;
    logic hit_tctrl;
    logic hit_tcount;
    logic hit_data;
    logic hit_prog;
    logic [7:0] data_idx;
    logic [PC_W-1:0] prog_idx;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    assign req = read | write;
    assign bus_we = write & ~wait_q;
    assign hit_ctrl = (address == REG_CTRL);
    assign hit_status = (address == REG_STATUS);
    assign hit_tctrl = (address == REG_TIMER_CTRL);
    assign hit_tcount = (address == REG_TIMER_COUNT);
    assign hit_data = (address[ADDR_W-1:DATA_WIN_LSB] == DATA_WIN_TAG);
    assign hit_prog = (address[ADDR_W-1:PROG_WIN_LSB] == PROG_WIN_TAG);
    assign data_idx = address[9:2];
    assign prog_idx = address[13:2];
    assign status_word = {4'h0, pc_q, 11'h000, in_isr_q, state_q == S_WAIT, state_q == S_STOP, c_q, z_q};
    assign rd_word = hit_ctrl ? {31'h0, run_q} :
                     hit_status ? status_word :
                     hit_tctrl ? {24'h0, tmr_ctrl} :
                     hit_tcount ? {24'h0, tmr_count} :
                     hit_data ? {24'h0, data_mem[data_idx]} :
                     hit_prog ? {24'h0, prog_mem[prog_idx]} : 32'h0;

    // One wait cycle per transfer; read data captured in that cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
            run_q <= 1'b0;
        end else if (ce) begin
            if (req && wait_q) begin
                wait_q <= 1'b0;
                rdata_q <= rd_word;
            end else begin
                wait_q <= 1'b1;
            end
            if (bus_we && hit_ctrl) run_q <= writedata[CTRL_RUN_BIT];
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;

    // Memories; the core write wins over a colliding bus write
    always_ff @(posedge clk) begin
        if (ce) begin
            if (commit && core_we) data_mem[waddr] <= wdata;
            else if (bus_we && hit_data) data_mem[data_idx] <= writedata[7:0];
            if (bus_we && hit_prog) prog_mem[prog_idx] <= writedata[7:0];
        end
    end

    // Timer hookup: full clock in run, gated in wait, frozen in stop
    logic core_tctrl;
    logic core_tcount;
    logic tmr_en;
    logic tmr_wr_ctrl;
    logic tmr_wr_count;
    logic [7:0] tmr_wdata;
    assign core_tctrl = commit & core_we & (waddr == TIMER_STATUS_CONTROL_ADDR);
    assign core_tcount = commit & core_we & (waddr == TCOUNT_ADDR);
    assign tmr_en = in_exec | (state_q == S_HALT) | ((state_q == S_WAIT) & tmr_ctrl[PSI_BIT]);
    assign tmr_wr_ctrl = core_tctrl | (bus_we & hit_tctrl & ~core_tcount);
    assign tmr_wr_count = core_tcount | (bus_we & hit_tcount & ~core_tctrl);
    assign tmr_wdata = (core_tctrl | core_tcount) ? wdata : writedata[7:0];

    cpu_timer #(
        .STAB_COUNT(STAB_COUNT)
    ) u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .count_en(tmr_en),
        .stab_load((state_q == S_STOP) & ~irq_n),
        .wr_ctrl(tmr_wr_ctrl),
        .wr_count(tmr_wr_count),
        .wr_data(tmr_wdata),
        .ctrl_q(tmr_ctrl),
        .count_q(tmr_count),
        .stab_q(tmr_stab)
    );
endmodule : cpu_core

// ---- test/irq_source.sv ----
`timescale 1ns/100ps
module irq_source (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Command from the bench
    input wire logic fire,
    // Active-low request, idle high
    output logic irq_n
);
    logic [2:0] hold_q;
    // Held low for several cycles so a sleeping core sees a level, not a glitch
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) hold_q <= 3'h0;
        else if (fire) hold_q <= 3'h6;
        else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    end
    assign irq_n = (hold_q == 3'h0);
endmodule : irq_source

// ---- test/cpu_core_properties.sv ----
`timescale 1ns/100ps
module cpu_core_properties
    import cpu_pkg::*;
(
    // Clock, reset and interrupt pin
    input wire logic clk,
    input wire logic arst_n,
    input wire logic irq_n,
    // Bus
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // One wait cycle per transfer, never two answers in a row
    chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("late answer");
    chk_answer_once: assert property (!waitrequest |=> waitrequest) else $error("answer too long");
    chk_answer_cause: assert property (!waitrequest |-> $past(read || write)) else $error("answer unasked");
    chk_idle_high: assert property (!(read || write) |=> waitrequest) else $error("idle answer");
    chk_reset_idle: assert property ($rose(arst_n) |-> waitrequest) else $error("busy after reset");
    // Read data may only move when a transfer was taken; writes reload it as well
    chk_read_hold: assert property (!((read || write) && waitrequest) |=> $stable(readdata))
        else $error("read data moved");
    chk_ctrl_upper: assert property (read && !waitrequest && address == REG_TIMER_CTRL |->
        readdata[31:8] == 24'h0) else $error("timer control upper bits");
    chk_unmapped_zero: assert property (read && !waitrequest && address == 15'h0010 |->
        readdata == 32'h0) else $error("unmapped read");
    // Main scenarios
    cover property (write && !waitrequest);
    cover property (read && !waitrequest);
    cover property (!irq_n);
endmodule : cpu_core_properties
bind cpu_core cpu_core_properties chk_u (.clk(clk), .arst_n(arst_n), .irq_n(irq_n), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest));

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import cpu_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic fire = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [14:0] address = 15'h0000;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rd, q;
    logic waitrequest, irq_n;
    int n_fail = 0;
    int n_tests = 0;
    always #4 clk = ~clk;
    // Small stabilisation count keeps the stop exit short
    cpu_core #(.IRQ_VECTOR(12'h0F0), .STAB_COUNT(8'h04)) dut_u (.clk(clk), .arst_n(arst_n), .ce(1'b1),
        .irq_n(irq_n), .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest));
    irq_source irq_u (.clk(clk), .arst_n(arst_n), .fire(fire), .irq_n(irq_n));
    task end_of_test;
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One bus transfer; request held until waitrequest is sampled low
    task bus(input logic wr, input logic [14:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    function automatic logic [14:0] pa(input logic [11:0] a);
        return 15'h4000 | 15'({a, 2'b00});
    endfunction : pa
    function automatic logic [14:0] da(input logic [7:0] a);
        return 15'h0400 | 15'({a, 2'b00});
    endfunction : da
    task rst;
        arst_n <= 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
    endtask : rst
    // Program bytes followed by a jump to itself, which marks the end
    task load(input logic [11:0] at, input logic [7:0] p[$]);
        logic [11:0] t;
        t = at + 12'(p.size());
        p.push_back({4'h9, t[11:8]});
        p.push_back(t[7:0]);
        foreach (p[i]) bus(1'b1, pa(at + 12'(i)), {24'h0, p[i]});
    endtask : load
    task upto(input logic [11:0] pc);
        do bus(1'b0, REG_STATUS, 32'h0); while (rd[27:16] !== pc);
    endtask : upto
    task t_alu;
        rst;
        load(12'h000, {8'hB0, 8'h80, 8'h20, 8'hB0, 8'h20, 8'h05, 8'hB0, 8'h81, 8'h40, 8'hE8, 8'h03,
            8'hE2, 8'hFA, 8'hFF, 8'hF1, 8'hF9, 8'h30, 8'hEB, 8'h10});
        bus(1'b1, REG_CTRL, 32'h1);
        upto(12'h013);
        chk("flags", {30'h0, rd[1:0]}, 32'h1);
        bus(1'b0, da(8'h30), 32'h0);
        chk("store direct", rd, 32'h10);
        bus(1'b0, da(8'h40), 32'h0);
        chk("store via y", rd, 32'h10);
        bus(1'b0, da(8'h80), 32'h0);
        chk("x constant", rd, 32'h20);
        bus(1'b0, da(8'hFF), 32'h0);
        chk("acc cleared", rd, 32'h0);
        bus(1'b0, 15'h0010, 32'h0);
        chk("unmapped", rd, 32'h0);
    endtask : t_alu
    // Tested bit lands in carry and is then rotated in
    task t_bits;
        rst;
        bus(1'b1, da(8'h50), 32'h04);
        bus(1'b1, da(8'h51), 32'h80);
        load(12'h000, {8'hE8, 8'h00, 8'hC2, 8'h50, 8'h00, 8'hB5, 8'hB4, 8'hF9, 8'h31, 8'hD8, 8'h51});
        bus(1'b1, REG_CTRL, 32'h1);
        upto(12'h00B);
        chk("carry set", {30'h0, rd[1:0]}, 32'h2);
        bus(1'b0, da(8'h31), 32'h0);
        chk("rotate then complement", rd, 32'hFE);
        bus(1'b0, da(8'h51), 32'h0);
        chk("bit set", rd, 32'h81);
    endtask : t_bits
    task t_branch;
        rst;
        load(12'h000, {8'hE8, 8'h00, 8'h21, 8'hB4, 8'hF9, 8'h32, 8'hE8, 8'h07, 8'h01, 8'hB4, 8'hF9, 8'h33,
            8'h41, 8'hB4, 8'hF9, 8'h34, 8'h61, 8'hB4, 8'hF9, 8'h35});
        bus(1'b1, REG_CTRL, 32'h1);
        upto(12'h014);
        bus(1'b0, da(8'h32), 32'h0);
        chk("equal taken", rd, 32'h00);
        bus(1'b0, da(8'h33), 32'h0);
        chk("not equal taken", rd, 32'h07);
        bus(1'b0, da(8'h34), 32'h0);
        chk("carry clear taken", rd, 32'h07);
        bus(1'b0, da(8'h35), 32'h0);
        chk("carry set skipped", rd, 32'hF8);
    endtask : t_branch
    // Short direct, AND, compare with borrow, bit clear, call and return
    task t_call;
        rst;
        load(12'h000, {8'hE8, 8'h3C, 8'hBE, 8'hAA, 8'hED, 8'h0F, 8'hEC, 8'h0D, 8'h80, 8'h0E, 8'hF9, 8'h36,
            8'h90, 8'h0C, 8'hD2, 8'h82, 8'hAE, 8'hB3});
        bus(1'b1, REG_CTRL, 32'h1);
        upto(12'h00C);
        chk("compare borrow", {30'h0, rd[1:0]}, 32'h2);
        bus(1'b0, da(8'h82), 32'h0);
        chk("short inc then clear", rd, 32'h39);
        bus(1'b0, da(8'h36), 32'h0);
        chk("call and return", rd, 32'h39);
    endtask : t_call
    // Timer reaching zero during wait wakes the core through the single vector
    task t_wait;
        rst;
        load(12'h0F0, {8'hB0, 8'h34, 8'hA5});
        load(12'h000, {8'hB7});
        bus(1'b1, REG_TIMER_COUNT, 32'h10);
        bus(1'b1, REG_TIMER_CTRL, 32'h28);
        bus(1'b1, REG_CTRL, 32'h1);
        upto(12'h0F3);
        chk("in service", {31'h0, rd[ST_ISR_BIT]}, 32'h1);
        bus(1'b0, da(8'h34), 32'h0);
        chk("vector code", rd, 32'hA5);
        bus(1'b0, REG_TIMER_CTRL, 32'h0);
        chk("timer zero flag", rd, 32'hA8);
    endtask : t_wait
    // Stop freezes the counter; only the request pin ends it
    task t_stop;
        rst;
        load(12'h000, {8'hB6});
        bus(1'b1, REG_TIMER_CTRL, 32'h08);
        bus(1'b1, REG_CTRL, 32'h1);
        do bus(1'b0, REG_STATUS, 32'h0); while (rd[ST_STOP_BIT] !== 1'b1);
        bus(1'b0, REG_TIMER_COUNT, 32'h0);
        q = rd;
        repeat (40) @(posedge clk);
        bus(1'b0, REG_TIMER_COUNT, 32'h0);
        chk("frozen counter", rd, q);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        upto(12'h0F3);
        bus(1'b0, REG_TIMER_CTRL, 32'h0);
        chk("control kept", rd, 32'h08);
    endtask : t_stop
    initial begin
        t_alu;
        t_bits;
        t_branch;
        t_call;
        t_wait;
        t_stop;
        end_of_test;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test;
    end
endmodule : testbench
